// *** ras_pkg.sv ***
/*
 * Shared constants for the return address stack: register offsets,
 * field positions, reset values and stack geometry.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package ras_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Stack geometry
   localparam int RAS_AW = 21;
   localparam int RAS_PW = 5;
   localparam logic [4:0] RAS_DEPTH = 5'h1F;
   localparam logic [4:0] RAS_PTR_RST = 5'h00;
   localparam logic [20:0] RAS_PC_SKIP = 21'h000002;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] RAS_OFS_PTR = 8'h00;
   localparam logic [7:0] RAS_OFS_TOPU = 8'h04;
   localparam logic [7:0] RAS_OFS_TOPH = 8'h08;
   localparam logic [7:0] RAS_OFS_TOPL = 8'h0C;
   localparam logic [7:0] RAS_OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] RAS_OFS_IRQ_MASK = 8'h14;

   ////////////////////////////////////////////////////////////////////////
   // Fields of the pointer register
   localparam int RAS_PTR_LSB = 0;
   localparam int RAS_UNF_BIT = 6;
   localparam int RAS_FUL_BIT = 7;

   // Fields of the interrupt status and mask registers
   localparam int RAS_EV_FUL = 0;
   localparam int RAS_EV_UNF = 1;
   localparam int RAS_EV_W = 2;
   localparam logic [1:0] RAS_MASK_RST = 2'h0;

   // Top entry byte slices
   localparam int RAS_U_LSB = 16;
   localparam int RAS_H_LSB = 8;
   localparam int RAS_L_LSB = 0;

   typedef enum logic [1:0] {
      RAS_OP_NONE,
      RAS_OP_PUSH,
      RAS_OP_POP
   } ras_op_e;

endpackage : ras_pkg

// *** ras_stack.sv ***
/*
 * Hardware return address stack with AHB-Lite register access.
 * Assumes: hresetn is the power-on reset; core_reset_req is any other
 * device reset, synchronous, active high. Core push/pop strobes are
 * one-cycle pulses synchronous to hclk; push and pop never coincide
 * (push wins if they do). Register reads take one wait state and
 * writes none, so the master must honour hreadyout. Only the low
 * 256 bytes of the slave's range decode; anything above reads zero.
 */
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// - Up to 31 nested calls or interrupts
// - Push PC on call, relative call, interrupt
// - Pop into PC on any return
// - PC latch registers untouched by calls/returns
// - 31x21 storage, 5-bit pointer, reset zero
// - Pointer zero has no storage behind it
// - Push: increment pointer, then write entry
// - Pop: read entry, then decrement pointer
// - Storage private; pointer readable and writable
// - Top-entry bytes read and replace current entry
// - Full flag after 31 unpopped pushes
// - Full cleared only by software or POR
// - Overflow reset: store PC+2, flag, reset
// - No overflow reset: pointer sticks at 31
// - Empty pop returns zero, sets underflow
// - Underflow sticks until software or POR
module ras_stack
   import ras_pkg::*;
(
   // Clock and power-on reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Core sequencing side
   input wire logic call_instr,
   input wire logic relative_call_instr,
   input wire logic irq_ack,
   input wire logic [20:0] pc_in,
   input wire logic return_instr,
   input wire logic return_with_literal_instr,
   input wire logic return_from_interrupt_instr,
   output logic [20:0] pop_pc,
   output logic pop_valid,
   // Device reset and configuration
   input wire logic core_reset_req,
   input wire logic overflow_reset_enable,
   output logic overflow_reset,
   // Interrupt
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // State

   // Index 0 has no entry behind it
   logic [RAS_AW-1:0] stack_mem [1:31];
   logic [RAS_PW-1:0] return_stack_pointer_r;
   logic stack_full_flag_r;
   logic stack_underflow_flag_r;
   logic [RAS_EV_W-1:0] irq_stat_r;
   logic [RAS_EV_W-1:0] irq_mask_r;

   // Bus data phase
   logic dp_act_r;
   logic dp_write_r;
   logic [7:0] dp_addr_r;
   logic dp_map_r;
   logic rd_wait_r;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite front end

   logic addr_take;
   assign addr_take = hsel & htrans[1] & hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_act_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_addr_r <= 8'h00;
         dp_map_r <= 1'b0;
      end else if (hready | ~dp_act_r) begin
         dp_act_r <= addr_take;
         dp_write_r <= hwrite;
         dp_addr_r <= {haddr[7:2], 2'h0};
         // Upper bits checked so a high address cannot alias a register
         dp_map_r <= (haddr[31:8] == 24'h000000);
      end
   end

   // Reads take one wait state so hrdata comes from a flop and
   // reflects any write finished just before
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         rd_wait_r <= 1'b0;
      else
         rd_wait_r <= dp_act_r & ~dp_write_r & ~rd_wait_r;
   end

   assign hreadyout = ~(dp_act_r & ~dp_write_r & ~rd_wait_r);
   assign hresp = 1'b0;

   logic wr_en;
   logic rd_cap;
   assign wr_en = dp_act_r & dp_write_r & dp_map_r;
   assign rd_cap = dp_act_r & ~dp_write_r & ~rd_wait_r;

   logic wr_ptr;
   logic wr_topu;
   logic wr_toph;
   logic wr_topl;
   logic wr_mask;
   assign wr_ptr = wr_en & hit(dp_addr_r, RAS_OFS_PTR);
   assign wr_topu = wr_en & hit(dp_addr_r, RAS_OFS_TOPU);
   assign wr_toph = wr_en & hit(dp_addr_r, RAS_OFS_TOPH);
   assign wr_topl = wr_en & hit(dp_addr_r, RAS_OFS_TOPL);
   assign wr_mask = wr_en & hit(dp_addr_r, RAS_OFS_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////
   // Operation decode

   ras_op_e op;
   always_comb begin
      if (call_instr | relative_call_instr | irq_ack)
         op = RAS_OP_PUSH;
      else if (return_instr | return_with_literal_instr |
               return_from_interrupt_instr)
         op = RAS_OP_POP;
      else
         op = RAS_OP_NONE;
   end

   // A pointer write in the same cycle is applied first
   logic [RAS_PW-1:0] ptr_base;
   assign ptr_base = wr_ptr ? hwdata[RAS_PTR_LSB +: RAS_PW]
                            : return_stack_pointer_r;

   logic [RAS_PW-1:0] ptr_inc;
   logic [RAS_PW-1:0] ptr_dec;
   logic at_top;
   logic push_ok;
   logic push_last;
   logic pop_empty;
   assign ptr_inc = ptr_base + 5'h01;
   assign ptr_dec = ptr_base - 5'h01;
   assign at_top = (ptr_base == RAS_DEPTH);
   assign push_ok = (op == RAS_OP_PUSH) & ~at_top;
   assign push_last = push_ok & (ptr_inc == RAS_DEPTH);
   assign pop_empty = (op == RAS_OP_POP) & (ptr_base == RAS_PTR_RST);

   logic do_ovf_reset;
   assign do_ovf_reset = push_last & overflow_reset_enable;

   logic full_set;
   logic unf_set;
   assign full_set = push_last;
   assign unf_set = pop_empty;

   ////////////////////////////////////////////////////////////////////////
   // Pointer

   // Any reset beats a push or pop falling in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         return_stack_pointer_r <= RAS_PTR_RST;
      end else if (core_reset_req | do_ovf_reset) begin
         return_stack_pointer_r <= RAS_PTR_RST;
      end else begin
         unique case (op)
            RAS_OP_PUSH:
               return_stack_pointer_r <= push_ok ? ptr_inc
                                                 : ptr_base;
            RAS_OP_POP:
               return_stack_pointer_r <= pop_empty ? RAS_PTR_RST
                                                   : ptr_dec;
            RAS_OP_NONE:
               return_stack_pointer_r <= ptr_base;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Storage; a hardware push wins over a top-entry write in one cycle

   logic [RAS_AW-1:0] push_val;
   assign push_val = do_ovf_reset ? pc_in + RAS_PC_SKIP : pc_in;

   logic [RAS_AW-1:0] top_cur;
   assign top_cur = (return_stack_pointer_r == RAS_PTR_RST) ?
                    '0 : stack_mem[return_stack_pointer_r];

   logic top_wr;
   assign top_wr = (wr_topu | wr_toph | wr_topl) &
                   (return_stack_pointer_r != RAS_PTR_RST);

   always_ff @(posedge hclk) begin
      if (push_ok) begin
         stack_mem[ptr_inc] <= push_val;
      end else if (top_wr) begin
         if (wr_topu)
            stack_mem[return_stack_pointer_r][RAS_AW-1:RAS_U_LSB] <=
               hwdata[RAS_AW-RAS_U_LSB-1:0];
         if (wr_toph)
            stack_mem[return_stack_pointer_r][RAS_U_LSB-1:RAS_H_LSB] <=
               hwdata[7:0];
         if (wr_topl)
            stack_mem[return_stack_pointer_r][RAS_H_LSB-1:RAS_L_LSB] <=
               hwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Return value to the core; only the PC sees it, never the latches

   // Empty pop hands back zero, which vectors the core to its reset
   logic [RAS_AW-1:0] pop_val;
   assign pop_val = (ptr_base == RAS_PTR_RST) ?
                    '0 : stack_mem[ptr_base];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pop_valid <= 1'b0;
      else
         pop_valid <= (op == RAS_OP_POP);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pop_pc <= '0;
      else if (op == RAS_OP_POP)
         pop_pc <= pop_val;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         overflow_reset <= 1'b0;
      else
         overflow_reset <= do_ovf_reset;
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags: kept over other resets, set beats a software clear

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         stack_full_flag_r <= 1'b0;
      else if (full_set)
         stack_full_flag_r <= 1'b1;
      else if (wr_ptr & ~hwdata[RAS_FUL_BIT])
         stack_full_flag_r <= 1'b0;
   end

   // A pop at zero in the cycle of a software clear keeps the flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         stack_underflow_flag_r <= 1'b0;
      else if (unf_set)
         stack_underflow_flag_r <= 1'b1;
      else if (wr_ptr & ~hwdata[RAS_UNF_BIT])
         stack_underflow_flag_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status (read clears) and mask

   logic rd_stat;
   logic [RAS_EV_W-1:0] ev;
   assign rd_stat = rd_cap & dp_map_r & hit(dp_addr_r, RAS_OFS_IRQ_STAT);
   assign ev = {unf_set, full_set};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq_stat_r <= '0;
      else if (rd_stat)
         irq_stat_r <= ev;
      else
         irq_stat_r <= irq_stat_r | ev;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq_mask_r <= RAS_MASK_RST;
      else if (wr_mask)
         irq_mask_r <= hwdata[RAS_EV_W-1:0];
   end

   assign irq = |(irq_stat_r & irq_mask_r);

   ////////////////////////////////////////////////////////////////////////
   // Read data

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (!dp_map_r) begin
         // Outside the register window: reads as zero
         rd_mux = 32'h0000_0000;
      end else if (hit(dp_addr_r, RAS_OFS_PTR)) begin
         rd_mux[RAS_PTR_LSB +: RAS_PW] = return_stack_pointer_r;
         rd_mux[RAS_UNF_BIT] = stack_underflow_flag_r;
         rd_mux[RAS_FUL_BIT] = stack_full_flag_r;
      end else if (hit(dp_addr_r, RAS_OFS_TOPU)) begin
         rd_mux[RAS_AW-RAS_U_LSB-1:0] =
            top_cur[RAS_AW-1:RAS_U_LSB];
      end else if (hit(dp_addr_r, RAS_OFS_TOPH)) begin
         rd_mux[7:0] = top_cur[RAS_U_LSB-1:RAS_H_LSB];
      end else if (hit(dp_addr_r, RAS_OFS_TOPL)) begin
         rd_mux[7:0] = top_cur[RAS_H_LSB-1:RAS_L_LSB];
      end else if (hit(dp_addr_r, RAS_OFS_IRQ_STAT)) begin
         rd_mux[RAS_EV_W-1:0] = irq_stat_r;
      end else if (hit(dp_addr_r, RAS_OFS_IRQ_MASK)) begin
         rd_mux[RAS_EV_W-1:0] = irq_mask_r;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (rd_cap)
         hrdata <= rd_mux;
   end

endmodule : ras_stack

// *** ras_stack_assertions.sv ***
/*
 * Concurrent checks on the return address stack ports.
 * Assumes one clock hclk and the async active-low reset hresetn.
 */
`timescale 1ns/1ps
module ras_stack_assertions
   import ras_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // Core
   input wire logic call_instr,
   input wire logic relative_call_instr,
   input wire logic irq_ack,
   input wire logic return_instr,
   input wire logic return_with_literal_instr,
   input wire logic return_from_interrupt_instr,
   input wire logic [20:0] pop_pc,
   input wire logic pop_valid,
   input wire logic overflow_reset_enable,
   input wire logic overflow_reset
);
   logic push;
   logic pop;
   assign push = call_instr | relative_call_instr | irq_ack;
   assign pop = return_instr | return_with_literal_instr
      | return_from_interrupt_instr;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_take;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence rd_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   okay_resp_a: assert property (hresp == 1'b0)
      else $error("bus response not OKAY");
   read_wait_a: assert property (rd_take |=> rd_wait)
      else $error("read wait state wrong");
   wait_cause_a: assert property ($fell(hreadyout) |-> $past(hsel
      && htrans[1] && hready && !hwrite))
      else $error("wait state without read");
   pop_answer_a: assert property (pop && !push |=> pop_valid)
      else $error("pop not answered");
   pop_quiet_a: assert property (!(pop && !push) |=> !pop_valid)
      else $error("answer without pop");
   pop_hold_a: assert property (!pop_valid |-> $stable(pop_pc))
      else $error("popped value moved");
   ovf_cause_a: assert property (overflow_reset |->
      $past(push && overflow_reset_enable))
      else $error("overflow reset without push");
   ovf_once_a: assert property (overflow_reset |=> !overflow_reset)
      else $error("overflow reset too long");
endmodule : ras_stack_assertions

bind ras_stack ras_stack_assertions u_ras_stack_assertions (.hclk, .hresetn,
   .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .call_instr,
   .relative_call_instr, .irq_ack, .return_instr, .return_with_literal_instr,
   .return_from_interrupt_instr, .pop_pc, .pop_valid, .overflow_reset_enable,
   .overflow_reset);

// *** ras_core_model.sv ***
/*
 * Sequencing side of the core: turns bench requests into strobes.
 * Assumes requests change just after a rising edge and last one cycle.
 */
`timescale 1ns/1ps
module ras_core_model
   import ras_pkg::*;
(
   // Bench requests
   input wire ras_op_e op_req,
   input wire logic [1:0] op_kind,
   input wire logic [20:0] op_pc,
   // Core strobes
   output logic call_instr,
   output logic relative_call_instr,
   output logic irq_ack,
   output logic return_instr,
   output logic return_with_literal_instr,
   output logic return_from_interrupt_instr,
   output logic [20:0] pc_in
);
   logic ph;
   logic pp;
   always_comb begin
      ph = op_req == RAS_OP_PUSH;
      pp = op_req == RAS_OP_POP;
      call_instr = ph && op_kind == 2'h0;
      relative_call_instr = ph && op_kind == 2'h1;
      irq_ack = ph && op_kind[1];
      return_instr = pp && op_kind == 2'h0;
      return_with_literal_instr = pp && op_kind == 2'h1;
      return_from_interrupt_instr = pp && op_kind[1];
      // Idle PC is scrambled so a stale value cannot pass
      pc_in = (ph || pp) ? op_pc : ~op_pc;
   end
endmodule : ras_core_model

// *** tb_top.sv ***
/*
 * Self-checking bench for the return address stack.
 * Assumes the AHB slave is the only one, so hready is its hreadyout.
 */
`timescale 1ns/1ps
module tb_top;
   import ras_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready, hreadyout, hresp, irq, pop_valid, overflow_reset;
   logic [31:0] hrdata, q;
   logic core_reset_req = 1'b0;
   logic overflow_reset_enable = 1'b0;
   ras_op_e op_req = RAS_OP_NONE;
   logic [1:0] op_kind = 2'h0;
   logic [20:0] op_pc = 21'h0;
   logic [20:0] pc_in, pop_pc;
   logic c0, c1, c2, r0, r1, r2, unf, ful;
   logic [31:0] seed = 32'h5394DAE2;
   logic [20:0] stk [0:31];
   int errors = 0;
   int tests_run = 0;
   int sp, i;
   always #10 hclk = ~hclk;
   assign hready = hreadyout;
   ras_core_model u_ras_core_model (.op_req, .op_kind, .op_pc,
      .call_instr(c0), .relative_call_instr(c1), .irq_ack(c2),
      .return_instr(r0), .return_with_literal_instr(r1),
      .return_from_interrupt_instr(r2), .pc_in);
   ras_stack u_ras_stack (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout,
      .hresp, .call_instr(c0), .relative_call_instr(c1), .irq_ack(c2),
      .pc_in, .return_instr(r0), .return_with_literal_instr(r1),
      .return_from_interrupt_instr(r2), .pop_pc, .pop_valid,
      .core_reset_req, .overflow_reset_enable, .overflow_reset, .irq);
   ////////////////////////////////////////////////////////////////////////
   function logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function logic [31:0] ptr_w(input int p, input logic u, input logic f);
      return {24'h0, f, u, 1'b0, 5'(p)};
   endfunction : ptr_w
   task finish_test;
      if (errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task wrdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin
            errors++;
            finish_test;
         end
         @(posedge hclk);
      end
   endtask : wrdy
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wrdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wrdy;
      q = hrdata;
   endtask : bus
   task core(input ras_op_e op);
      logic [20:0] pc;
      logic ov;
      seed = xs(seed);
      ov = 1'b0;
      pc = seed[20:0];
      op_req <= op;
      op_kind <= seed[22:21];
      op_pc <= pc;
      @(posedge hclk);
      op_req <= RAS_OP_NONE;
      if (op == RAS_OP_PUSH && sp < 31) begin
         sp++;
         stk[sp] = pc;
         if (sp == 31) begin
            ful = 1'b1;
            if (overflow_reset_enable) begin
               stk[31] = pc + RAS_PC_SKIP;
               sp = 0;
               ov = 1'b1;
            end
         end
      end
      @(posedge hclk);
      chk({31'h0, overflow_reset}, {31'h0, ov});
      if (op == RAS_OP_POP) begin
         chk({31'h0, pop_valid}, 32'h1);
         chk({11'h0, pop_pc}, sp ? {11'h0, stk[sp]} : 32'h0);
         if (sp != 0)
            sp--;
         else
            unf = 1'b1;
      end
   endtask : core
   task top_chk;
      bus(1'b0, RAS_OFS_TOPU, 32'h0);
      chk(q, {27'h0, stk[sp][20:16]});
      bus(1'b0, RAS_OFS_TOPH, 32'h0);
      chk(q, {24'h0, stk[sp][15:8]});
      bus(1'b0, RAS_OFS_TOPL, 32'h0);
      chk(q, {24'h0, stk[sp][7:0]});
   endtask : top_chk
   task ptr_chk;
      bus(1'b0, RAS_OFS_PTR, 32'h0);
      chk(q, ptr_w(sp, unf, ful));
   endtask : ptr_chk
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sp = 0;
      unf = 1'b0;
      ful = 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ptr_chk;
      bus(1'b0, RAS_OFS_IRQ_MASK, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h18, 32'h0);
      chk(q, 32'h0);
      for (i = 0; i < 60; i++)
         core(seed[3] ? RAS_OP_PUSH : RAS_OP_POP);
      ptr_chk;
      bus(1'b1, RAS_OFS_PTR, 32'h0);
      {sp, unf, ful} = 0;
      repeat (32) core(RAS_OP_PUSH);
      ptr_chk;
      top_chk;
      // No core traffic while software edits the top entry
      bus(1'b1, RAS_OFS_TOPL, 32'hA5);
      stk[31][7:0] = 8'hA5;
      core(RAS_OP_POP);
      bus(1'b0, RAS_OFS_IRQ_STAT, 32'h0);
      chk({31'h0, q[0]}, 32'h1);
      bus(1'b1, RAS_OFS_IRQ_MASK, 32'h1);
      sp = 0;
      bus(1'b1, RAS_OFS_PTR, 32'h80);
      core(RAS_OP_POP);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, RAS_OFS_IRQ_MASK, 32'h3);
      // Mask lands at the closing edge of the write
      @(posedge hclk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, RAS_OFS_IRQ_STAT, 32'h0);
      chk(q, 32'h2);
      chk({31'h0, irq}, 32'h0);
      // Non-POR reset must drop a live pointer yet keep both flags
      core(RAS_OP_PUSH);
      core_reset_req <= 1'b1;
      @(posedge hclk);
      core_reset_req <= 1'b0;
      sp = 0;
      ptr_chk;
      bus(1'b1, RAS_OFS_PTR, 32'h0);
      {sp, unf, ful} = 0;
      overflow_reset_enable <= 1'b1;
      repeat (31) core(RAS_OP_PUSH);
      ptr_chk;
      bus(1'b1, RAS_OFS_PTR, 32'h9F);
      sp = 31;
      top_chk;
      core(RAS_OP_POP);
      chk({31'h0, irq}, 32'h1);
      // Power-on reset clears pointer, both flags and the interrupt
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      {sp, unf, ful} = 0;
      ptr_chk;
      chk({31'h0, irq}, 32'h0);
      finish_test;
   end
endmodule : tb_top
